/* pbs_pkg.sv */
package pbs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int NS_PER_MS      = 1000000;
	localparam int LONG_PRESS_MS  = 1000;
	localparam int CLICK_GAP_MS   = 1000;
	localparam int DEBOUNCE_MS    = 10;
	// Least times round up, longest times round down
	localparam int LONG_PRESS_CYC =
		(LONG_PRESS_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLICK_GAP_CYC  = CLICK_GAP_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int DEBOUNCE_CYC   =
		(DEBOUNCE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Sizes and limits
	// ----------------------------------------------------------------
	localparam int       NUM_BUTTONS = 11;
	localparam int       SEL_W       = 4;
	localparam int       PTR_W       = 6;
	localparam int       LEN_W       = 7;
	localparam int       MEM_AW      = SEL_W + 1 + PTR_W;
	localparam int       STG_DEPTH   = 64;
	localparam logic [6:0] NAME_MAX  = 7'h21;
	localparam logic [6:0] LABEL_MAX = 7'h1e;
	localparam logic [6:0] SEMI_MAX  = 7'h02;
	localparam logic [7:0] PICT_MAX  = 8'h8c;
	localparam logic [7:0] SEMI_CHAR = 8'h3b;
	localparam logic [7:0] TALLY_MAX = 8'hff;

	// ----------------------------------------------------------------
	// Modes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_MOMENTARY   = 3'h0;
	localparam logic [2:0] MODE_TOGGLE      = 3'h1;
	localparam logic [2:0] MODE_RADIO_FIRST = 3'h2;
	localparam logic [2:0] MODE_RADIO_LAST  = 3'h6;

	// ----------------------------------------------------------------
	// Register offsets and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SEL      = 8'h00;
	localparam logic [7:0] OFS_CFG      = 8'h04;
	localparam logic [7:0] OFS_STATE    = 8'h08;
	localparam logic [7:0] OFS_LATCH    = 8'h0c;
	localparam logic [7:0] OFS_LEVEL    = 8'h10;
	localparam logic [7:0] OFS_LONG     = 8'h14;
	localparam logic [7:0] OFS_TALLY    = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFS_TXT_CTRL = 8'h24;
	localparam logic [7:0] OFS_TXT_DATA = 8'h28;
	localparam logic [7:0] OFS_TXT_RPTR = 8'h2c;
	localparam logic [7:0] OFS_TXT_RDAT = 8'h30;
	localparam int CFG_PICT_LSB   = 8;
	localparam int TXT_GO_BIT     = 0;
	localparam int TXT_KIND_BIT   = 1;
	localparam int TXT_CLR_BIT    = 8;
	localparam int TXT_NAME_LSB   = 8;
	localparam int TXT_LABEL_LSB  = 16;
	localparam int IRQ_W          = 6;
	localparam int IRQ_PRESS      = 0;
	localparam int IRQ_RELEASE    = 1;
	localparam int IRQ_LONG       = 2;
	localparam int IRQ_SEQ_END    = 3;
	localparam int IRQ_REJECT     = 4;
	localparam int IRQ_DONE       = 5;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} pbs_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pbs_apb_rsp_type;

	typedef struct packed {
		logic level;
		logic press;
		logic release_;
	} pbs_key_evt_type;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_COPY = 2'b10
	} pbs_txfsm_type;

endpackage

/* pbs_debounce.sv */
`timescale 1ns/1ns
module pbs_debounce import pbs_pkg::*; #(
	parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            reset,
	// Raw key, high while pressed
	input  wire logic            key_raw,
	// Filtered key
	output pbs_key_evt_type      evt
);

	typedef struct packed {
		logic            sync0;
		logic            sync1;
		logic [31:0]     cnt;
		pbs_key_evt_type evt;
	} pbs_deb_type;

	pbs_deb_type s_r;
	pbs_deb_type s_nxt;

	// ----------------------------------------------------------------
	// Filter
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync0 = key_raw;
		s_nxt.sync1 = s_r.sync0;
		s_nxt.evt.press = 1'b0;
		s_nxt.evt.release_ = 1'b0;
		if (s_r.sync1 != s_r.evt.level) begin
			if (s_r.cnt >= 32'(DEB_CYC) - 32'h1) begin
				s_nxt.cnt = 32'h0;
				s_nxt.evt.level = s_r.sync1;
				s_nxt.evt.press = s_r.sync1;
				s_nxt.evt.release_ = ~s_r.sync1;
			end else begin
				s_nxt.cnt = s_r.cnt + 32'h1;
			end
		end else begin
			s_nxt.cnt = 32'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign evt = s_r.evt;

endmodule

/* pbs_button_state.sv */
// Operation
// - Momentary: state follows key held
// - Toggle: press inverts state, release keeps
// - Radio: press sets own, clears group
// - Mode values two to six: groups one-five
// - State readable, writable, write reads back
// - Latch inverts every press, any mode
// - Present level: down while held
// - Count presses within one second gaps
// - Tally returns zero after sequence ends
// - Long flag when held over one second
// - Names up to 33 characters, longer rejected
// - Pictogram values 1 to 140 accepted
// - Label: three rows, 30 characters total
// - Pictogram zero clears icon and label
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
module pbs_button_state import pbs_pkg::*; #(
	parameter int          NBTN     = NUM_BUTTONS,
	parameter int unsigned LONG_CYC = LONG_PRESS_CYC,
	parameter int unsigned GAP_CYC  = CLICK_GAP_CYC,
	parameter int unsigned DEB_CYC  = DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// APB slave
	input  pbs_apb_req_type       apb_req,
	output pbs_apb_rsp_type       apb_rsp,
	// Keys, high while pressed
	input  wire logic [NBTN-1:0]  key_raw,
	// Interaction state and interrupt
	output logic      [NBTN-1:0]  button_state,
	output logic                  irq
);

	typedef struct packed {
		logic [SEL_W-1:0]             sel;
		logic [NBTN-1:0][2:0]         mode;
		logic [NBTN-1:0][7:0]         pict;
		logic [NBTN-1:0][LEN_W-1:0]   name_len;
		logic [NBTN-1:0][LEN_W-1:0]   label_len;
		logic [NBTN-1:0]              state;
		logic [NBTN-1:0]              latch;
		logic [NBTN-1:0]              long_flag;
		logic [NBTN-1:0]              level;
		logic [NBTN-1:0][7:0]         tally;
		logic [NBTN-1:0][31:0]        hold_cnt;
		logic [NBTN-1:0][31:0]        gap_cnt;
		logic [NBTN-1:0]              gap_run;
		logic [IRQ_W-1:0]             irq_stat;
		logic [IRQ_W-1:0]             irq_mask;
		logic [PTR_W:0]               rptr;
		logic [LEN_W-1:0]             stg_len;
		logic [LEN_W-1:0]             stg_glyph;
		logic [LEN_W-1:0]             stg_semi;
		logic                         stg_ovf;
		logic                         cp_kind;
		logic [SEL_W-1:0]             cp_btn;
		logic [LEN_W-1:0]             cp_ptr;
		pbs_txfsm_type                fsm;
		pbs_apb_rsp_type              rsp;
		logic                         irq;
	} pbs_regs_type;

	pbs_regs_type      s_r;
	pbs_regs_type      s_nxt;
	pbs_key_evt_type   key_evt [NBTN];

	// Text memories, kept out of the state record
	logic [7:0]        text_mem [0:(1<<MEM_AW)-1];
	logic [7:0]        stg_mem  [0:STG_DEPTH-1];
	logic              mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [7:0]        mem_wdata;
	logic              stg_we;
	logic [PTR_W-1:0]  stg_addr;
	logic [7:0]        stg_wdata;

	// ----------------------------------------------------------------
	// Key filters
	// ----------------------------------------------------------------
	// filter each key first
	genvar gi;
	generate
		for (gi = 0; gi < NBTN; gi++) begin : g_key
			pbs_debounce #(
				.DEB_CYC (DEB_CYC)
			) u_deb (
				.ref_clk (ref_clk),
				.reset   (reset),
				.key_raw (key_raw[gi]),
				.evt     (key_evt[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic              setup;
		logic              acc_wr;
		logic [7:0]        ofs;
		logic              mapped;
		logic [31:0]       rd;
		logic [IRQ_W-1:0]  ev;
		logic [IRQ_W-1:0]  w1c;
		logic [2:0]        mode_w;
		logic [7:0]        pict_w;
		logic [7:0]        ch;
		logic              ok;
		s_nxt = s_r;
		setup = apb_req.psel & ~apb_req.penable;
		acc_wr = apb_req.psel & apb_req.penable & s_r.rsp.pready &
			apb_req.pwrite;
		ofs = apb_req.paddr[7:0];
		mapped = 1'b0;
		rd = 32'h0;
		ev = '0;
		w1c = '0;
		mode_w = apb_req.pwdata[2:0];
		pict_w = apb_req.pwdata[CFG_PICT_LSB +: 8];
		ch = apb_req.pwdata[7:0];
		ok = 1'b0;
		mem_we = 1'b0;
		mem_addr = '0;
		mem_wdata = 8'h0;
		stg_we = 1'b0;
		stg_addr = s_r.stg_len[PTR_W-1:0];
		stg_wdata = ch;

		// Read decode in the setup cycle
		if (apb_req.paddr[31:8] != 24'h0) begin
			mapped = 1'b0;
		end else if (ofs == OFS_SEL) begin
			mapped = 1'b1;
			rd[SEL_W-1:0] = s_r.sel;
		end else if (ofs == OFS_CFG) begin
			mapped = 1'b1;
			rd[2:0] = s_r.mode[s_r.sel];
			rd[CFG_PICT_LSB +: 8] = s_r.pict[s_r.sel];
		end else if (ofs == OFS_STATE) begin
			mapped = 1'b1;
			rd[NBTN-1:0] = s_r.state;
		end else if (ofs == OFS_LATCH) begin
			mapped = 1'b1;
			rd[NBTN-1:0] = s_r.latch;
		end else if (ofs == OFS_LEVEL) begin
			mapped = 1'b1;
			rd[NBTN-1:0] = s_r.level;
		end else if (ofs == OFS_LONG) begin
			mapped = 1'b1;
			rd[NBTN-1:0] = s_r.long_flag;
		end else if (ofs == OFS_TALLY) begin
			mapped = 1'b1;
			rd[7:0] = s_r.tally[s_r.sel];
		end else if (ofs == OFS_IRQ_STAT) begin
			mapped = 1'b1;
			rd[IRQ_W-1:0] = s_r.irq_stat;
		end else if (ofs == OFS_IRQ_MASK) begin
			mapped = 1'b1;
			rd[IRQ_W-1:0] = s_r.irq_mask;
		end else if (ofs == OFS_TXT_CTRL) begin
			mapped = 1'b1;
			rd[0] = (s_r.fsm == TX_COPY);
			rd[TXT_NAME_LSB +: LEN_W] = s_r.name_len[s_r.sel];
			rd[TXT_LABEL_LSB +: LEN_W] = s_r.label_len[s_r.sel];
		end else if (ofs == OFS_TXT_DATA) begin
			mapped = 1'b1;
			rd[LEN_W-1:0] = s_r.stg_len;
		end else if (ofs == OFS_TXT_RPTR) begin
			mapped = 1'b1;
			rd[PTR_W:0] = s_r.rptr;
		end else if (ofs == OFS_TXT_RDAT) begin
			mapped = 1'b1;
			rd[7:0] = text_mem[{s_r.sel, s_r.rptr}];
		end
		s_nxt.rsp.pready = setup;
		if (setup) begin
			s_nxt.rsp.prdata = rd;
			s_nxt.rsp.pslverr = ~mapped;
		end

		// Register writes in the access cycle
		if (acc_wr && apb_req.paddr[31:8] == 24'h0) begin
			if (ofs == OFS_SEL) begin
				if (apb_req.pwdata[SEL_W-1:0] < SEL_W'(NBTN)) begin
					s_nxt.sel = apb_req.pwdata[SEL_W-1:0];
				end else begin
					ev[IRQ_REJECT] = 1'b1;
				end
			end else if (ofs == OFS_CFG) begin
				// modes above radio group five refused
				if (mode_w > MODE_RADIO_LAST || pict_w > PICT_MAX) begin
					ev[IRQ_REJECT] = 1'b1;
				end else begin
					s_nxt.mode[s_r.sel] = mode_w;
					s_nxt.pict[s_r.sel] = pict_w;
					if (pict_w == 8'h0) begin
						s_nxt.label_len[s_r.sel] = '0;
					end
				end
			end else if (ofs == OFS_STATE) begin
				s_nxt.state = apb_req.pwdata[NBTN-1:0];
			end else if (ofs == OFS_IRQ_STAT) begin
				w1c = apb_req.pwdata[IRQ_W-1:0];
			end else if (ofs == OFS_IRQ_MASK) begin
				s_nxt.irq_mask = apb_req.pwdata[IRQ_W-1:0];
			end else if (ofs == OFS_TXT_RPTR) begin
				s_nxt.rptr = apb_req.pwdata[PTR_W:0];
			end else if (ofs == OFS_TXT_DATA) begin
				if (s_r.fsm == TX_COPY) begin
					ev[IRQ_REJECT] = 1'b1;
				end else if (apb_req.pwdata[TXT_CLR_BIT]) begin
					s_nxt.stg_len = '0;
					s_nxt.stg_glyph = '0;
					s_nxt.stg_semi = '0;
					s_nxt.stg_ovf = 1'b0;
				end else if (s_r.stg_len == LEN_W'(STG_DEPTH)) begin
					s_nxt.stg_ovf = 1'b1;
				end else begin
					stg_we = 1'b1;
					s_nxt.stg_len = s_r.stg_len + 7'h1;
					if (ch == SEMI_CHAR) begin
						s_nxt.stg_semi = s_r.stg_semi + 7'h1;
					end else begin
						s_nxt.stg_glyph = s_r.stg_glyph + 7'h1;
					end
				end
			end else if (ofs == OFS_TXT_CTRL) begin
				if (apb_req.pwdata[TXT_GO_BIT]) begin
					if (apb_req.pwdata[TXT_KIND_BIT]) begin
						ok = ~s_r.stg_ovf &&
							s_r.stg_glyph <= LABEL_MAX &&
							s_r.stg_semi <= SEMI_MAX;
					end else begin
						ok = ~s_r.stg_ovf && s_r.stg_len <= NAME_MAX;
					end
					if (!ok || s_r.fsm == TX_COPY) begin
						ev[IRQ_REJECT] = 1'b1;
					end else if (s_r.stg_len == '0) begin
						ev[IRQ_DONE] = 1'b1;
						if (apb_req.pwdata[TXT_KIND_BIT]) begin
							s_nxt.label_len[s_r.sel] = '0;
						end else begin
							s_nxt.name_len[s_r.sel] = '0;
						end
					end else begin
						s_nxt.cp_kind = apb_req.pwdata[TXT_KIND_BIT];
						s_nxt.cp_btn = s_r.sel;
						s_nxt.cp_ptr = '0;
						s_nxt.fsm = TX_COPY;
					end
				end
			end
		end

		// Staged text copied one byte a cycle
		case (s_r.fsm)
			TX_IDLE: begin
			end
			TX_COPY: begin
				mem_we = 1'b1;
				mem_addr = {s_r.cp_btn, s_r.cp_kind,
					s_r.cp_ptr[PTR_W-1:0]};
				mem_wdata = stg_mem[s_r.cp_ptr[PTR_W-1:0]];
				s_nxt.cp_ptr = s_r.cp_ptr + 7'h1;
				if (s_r.cp_ptr + 7'h1 == s_r.stg_len) begin
					if (s_r.cp_kind) begin
						s_nxt.label_len[s_r.cp_btn] = s_r.stg_len;
					end else begin
						s_nxt.name_len[s_r.cp_btn] = s_r.stg_len;
					end
					s_nxt.stg_len = '0;
					s_nxt.stg_glyph = '0;
					s_nxt.stg_semi = '0;
					ev[IRQ_DONE] = 1'b1;
					s_nxt.fsm = TX_IDLE;
				end
			end
			default: begin
				s_nxt.fsm = TX_IDLE;
			end
		endcase

		// Key events act after a software state write
		for (int i = 0; i < NBTN; i++) begin
			s_nxt.level[i] = key_evt[i].level;
			if (key_evt[i].press) begin
				ev[IRQ_PRESS] = 1'b1;
				s_nxt.latch[i] = ~s_r.latch[i];
				if (s_r.mode[i] == MODE_MOMENTARY) begin
					s_nxt.state[i] = 1'b1;
				end else if (s_r.mode[i] == MODE_TOGGLE) begin
					s_nxt.state[i] = ~s_nxt.state[i];
				end else begin
					for (int j = 0; j < NBTN; j++) begin
						if (j != i && s_r.mode[j] == s_r.mode[i]) begin
							s_nxt.state[j] = 1'b0;
						end
					end
					s_nxt.state[i] = 1'b1;
				end
				if (s_r.tally[i] != TALLY_MAX) begin
					s_nxt.tally[i] = s_r.tally[i] + 8'h1;
				end
				s_nxt.gap_run[i] = 1'b0;
				s_nxt.hold_cnt[i] = 32'h0;
				s_nxt.long_flag[i] = 1'b0;
			end
			if (key_evt[i].release_) begin
				ev[IRQ_RELEASE] = 1'b1;
				if (s_r.mode[i] == MODE_MOMENTARY) begin
					s_nxt.state[i] = 1'b0;
				end
				s_nxt.gap_run[i] = 1'b1;
				s_nxt.gap_cnt[i] = 32'h0;
			end
			if (s_r.gap_run[i] && !key_evt[i].press) begin
				if (s_r.gap_cnt[i] >= 32'(GAP_CYC)) begin
					s_nxt.tally[i] = 8'h0;
					s_nxt.gap_run[i] = 1'b0;
					ev[IRQ_SEQ_END] = 1'b1;
				end else begin
					s_nxt.gap_cnt[i] = s_r.gap_cnt[i] + 32'h1;
				end
			end
			if (s_r.level[i] && key_evt[i].level && !s_r.long_flag[i]) begin
				if (s_r.hold_cnt[i] >= 32'(LONG_CYC)) begin
					s_nxt.long_flag[i] = 1'b1;
					ev[IRQ_LONG] = 1'b1;
				end else begin
					s_nxt.hold_cnt[i] = s_r.hold_cnt[i] + 32'h1;
				end
			end
		end

		// New events win over a clear in the same cycle
		s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.fsm <= TX_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// No reset on the text stores; lengths gate their use
	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			text_mem[mem_addr] <= mem_wdata;
		end
		if (stg_we) begin
			stg_mem[stg_addr] <= stg_wdata;
		end
	end

	assign apb_rsp      = s_r.rsp;
	assign button_state = s_r.state;
	assign irq          = s_r.irq;

endmodule

/* pbs_checker.sv */
`timescale 1ns/1ns
module pbs_checker import pbs_pkg::*; #(
	parameter int NBTN    = NUM_BUTTONS,
	parameter int DEB_CYC = DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic            ref_clk,
	input wire logic            reset,
	// Bus
	input pbs_apb_req_type      apb_req,
	input pbs_apb_rsp_type      apb_rsp,
	// Keys and outputs
	input wire logic [NBTN-1:0] key_raw,
	input wire logic [NBTN-1:0] button_state,
	input wire logic            irq
);
	// ----
	// Helpers
	// ----
	// Cycles since a raw key moved, saturating
	logic [7:0]      quiet_r;
	logic [NBTN-1:0] key_prev_r;
	logic [NBTN-1:0] wdata_r;
	logic            wr_done;
	assign wr_done = apb_req.psel & apb_req.penable & apb_rsp.pready
		& apb_req.pwrite;
	always_ff @(posedge ref_clk) begin
		key_prev_r <= key_raw;
		wdata_r <= apb_req.pwdata[NBTN-1:0];
		if (reset || key_raw != key_prev_r)
			quiet_r <= 8'h00;
		else if (quiet_r != 8'hff)
			quiet_r <= quiet_r + 8'h01;
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_state_wr;
		wr_done && apb_req.paddr == {24'h0, OFS_STATE};
	endsequence
	property p_ready_next;
		s_setup |=> apb_rsp.pready;
	endproperty
	property p_ready_pulse;
		apb_rsp.pready |=> !apb_rsp.pready;
	endproperty
	property p_ready_cause;
		apb_rsp.pready |-> $past(apb_req.psel) && !$past(apb_req.penable);
	endproperty
	property p_bad_addr;
		s_setup ##0 (apb_req.paddr[31:8] != 24'h0) |=> apb_rsp.pslverr;
	endproperty
	property p_good_addr;
		s_setup ##0 (apb_req.paddr == {24'h0, OFS_STATE})
			|=> !apb_rsp.pslverr;
	endproperty
	property p_state_rd;
		s_setup ##0 (!apb_req.pwrite && apb_req.paddr == {24'h0, OFS_STATE})
			|=> apb_rsp.prdata[NBTN-1:0] == $past(button_state);
	endproperty
	// A key event in the same cycle would win, so keys must be quiet
	property p_state_echo;
		s_state_wr ##0 (quiet_r > 8'(DEB_CYC + 8)) |=> button_state == wdata_r;
	endproperty
	property p_state_cause;
		$changed(button_state) |-> $past(wr_done)
			|| (quiet_r >= 8'(DEB_CYC) && quiet_r <= 8'(DEB_CYC + 8));
	endproperty
	a_ready_next: assert property (p_ready_next)
		else $error("no pready after setup");
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (p_ready_cause)
		else $error("pready without setup");
	a_bad_addr: assert property (p_bad_addr)
		else $error("far address not refused");
	a_good_addr: assert property (p_good_addr)
		else $error("state access refused");
	a_state_rd: assert property (p_state_rd)
		else $error("state read differs");
	a_state_echo: assert property (p_state_echo)
		else $error("state write not applied");
	a_state_cause: assert property (p_state_cause)
		else $error("state moved without filtered key or write");
endmodule

bind pbs_button_state pbs_checker #(
	.NBTN    (NBTN),
	.DEB_CYC (DEB_CYC)
) i_pbs_checker (
	.ref_clk      (ref_clk),
	.reset        (reset),
	.apb_req      (apb_req),
	.apb_rsp      (apb_rsp),
	.key_raw      (key_raw),
	.button_state (button_state),
	.irq          (irq)
);

/* pbs_key_model.sv */
`timescale 1ns/1ns
module pbs_key_model import pbs_pkg::*; #(
	parameter int NBTN = NUM_BUTTONS
) (
	// Clock
	input  wire logic [0:0]      ref_clk,
	// Finger position, then contact
	input  wire logic [NBTN-1:0] want,
	output logic      [NBTN-1:0] key_raw
);
	// Contacts chatter in one-cycle glitches before settling,
	// always shorter than the filter window
	logic [NBTN-1:0] tgt_r = '0;
	logic [NBTN-1:0] old_r = '0;
	logic [2:0]      bnc_r = 3'h0;
	initial key_raw = '0;
	always @(posedge ref_clk) begin
		if (want !== tgt_r) begin
			old_r <= tgt_r;
			tgt_r <= want;
			bnc_r <= 3'h5;
		end else if (bnc_r != 3'h0) begin
			bnc_r <= bnc_r - 3'h1;
		end
		key_raw <= (bnc_r[0] || bnc_r == 3'h0) ? tgt_r : old_r;
	end
endmodule

/* panel_button_state_logic_tb.sv */
`timescale 1ns/1ns
module panel_button_state_logic_tb import pbs_pkg::*; ;
	localparam int DEB   = 4;
	localparam int LNG   = 50;
	localparam int GAP   = 40;
	localparam int LIMIT = 40000;
	logic                   ref_clk = 1'b0;
	logic                   reset   = 1'b1;
	pbs_apb_req_type        apb_req = '0;
	pbs_apb_rsp_type        apb_rsp;
	logic [NUM_BUTTONS-1:0] want    = '0;
	logic [NUM_BUTTONS-1:0] key_raw;
	logic [NUM_BUTTONS-1:0] button_state;
	logic                   irq;
	logic [31:0]            rdata;
	logic                   rerr;
	int                     err_total   = 0;
	int                     check_count = 0;
	int                     cyc         = 0;
	always #5 ref_clk = ~ref_clk;
	pbs_button_state #(.LONG_CYC(LNG), .GAP_CYC(GAP), .DEB_CYC(DEB))
	i_pbs_button_state (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.apb_req      (apb_req),
		.apb_rsp      (apb_rsp),
		.key_raw      (key_raw),
		.button_state (button_state),
		.irq          (irq)
	);
	pbs_key_model i_pbs_key_model (
		.ref_clk (ref_clk),
		.want    (want),
		.key_raw (key_raw)
	);
	// ----
	// Shared tasks
	// ----
	task end_sim;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total++;
			end_sim();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= w;
		apb_req.paddr <= a;
		apb_req.pwdata <= d;
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (apb_rsp.pready !== 1'b1);
		// Answer comes in the first access cycle
		chk(32'(n), 32'h1);
		rdata = apb_rsp.prdata;
		rerr = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, {24'h0, a}, d);
	endtask
	task rd(input logic [7:0] a);
		apb(1'b0, {24'h0, a}, 32'h0);
	endtask
	task key(input int b, input logic v);
		want[b] <= v;
		repeat (DEB + 16) @(posedge ref_clk);
	endtask
	task setmode(input logic [3:0] b, input logic [2:0] m);
		wr(OFS_SEL, {28'h0, b});
		wr(OFS_CFG, {29'h0, m});
	endtask
	task put_text(input logic kind, input int len, input int semis);
		int n;
		n = 0;
		wr(OFS_TXT_DATA, 32'h100);
		for (int i = 0; i < len; i++)
			wr(OFS_TXT_DATA, (i < semis) ? 32'(SEMI_CHAR) : 32'h41);
		wr(OFS_TXT_CTRL, {30'h0, kind, 1'b1});
		do begin
			rd(OFS_TXT_CTRL);
			n++;
		end while (rdata[0] !== 1'b0 && n < 80);
	endtask
	// ----
	// Scenarios
	// ----
	task t_regs;
		rd(OFS_STATE);
		chk(rdata, 32'h0);
		rd(OFS_TALLY);
		chk(rdata, 32'h0);
		apb(1'b1, 32'h0000_0100, 32'h1);
		chk(32'(rerr), 32'h1);
		wr(OFS_STATE, 32'h5a5);
		rd(OFS_STATE);
		chk(rdata, 32'h5a5);
		wr(OFS_STATE, 32'h0);
		wr(OFS_CFG, 32'h7);
		rd(OFS_CFG);
		chk(rdata, 32'h0);
	endtask
	task t_moment;
		setmode(4'h0, MODE_MOMENTARY);
		wr(OFS_IRQ_MASK, 32'h1);
		key(0, 1'b1);
		chk(32'(button_state[0]), 32'h1);
		chk(32'(irq), 32'h1);
		rd(OFS_LEVEL);
		chk(rdata & 32'h1, 32'h1);
		wr(OFS_IRQ_STAT, 32'h3f);
		key(0, 1'b0);
		chk(32'(button_state[0]), 32'h0);
		chk(32'(irq), 32'h0);
		rd(OFS_LEVEL);
		chk(rdata & 32'h1, 32'h0);
		wr(OFS_IRQ_MASK, 32'h0);
	endtask
	task t_toggle;
		logic [31:0] l0;
		setmode(4'h0, MODE_TOGGLE);
		rd(OFS_LATCH);
		l0 = rdata;
		key(0, 1'b1);
		chk(32'(button_state[0]), 32'h1);
		rd(OFS_LATCH);
		chk(rdata & 32'h1, ~l0 & 32'h1);
		key(0, 1'b0);
		chk(32'(button_state[0]), 32'h1);
		key(0, 1'b1);
		key(0, 1'b0);
		chk(32'(button_state[0]), 32'h0);
		rd(OFS_LATCH);
		chk(rdata & 32'h1, l0 & 32'h1);
	endtask
	task t_radio;
		setmode(4'h0, MODE_MOMENTARY);
		for (int g = 2; g <= 6; g++) begin
			setmode(4'h1, 3'(g));
			setmode(4'h2, 3'(g));
			setmode(4'h3, (g == 6) ? 3'h2 : 3'(g + 1));
			wr(OFS_STATE, 32'h00c);
			key(1, 1'b1);
			chk(32'(button_state), 32'h00a);
			key(1, 1'b0);
		end
	endtask
	task t_clicks;
		setmode(4'h0, MODE_MOMENTARY);
		wr(OFS_IRQ_STAT, 32'h3f);
		key(0, 1'b1);
		key(0, 1'b0);
		key(0, 1'b1);
		key(0, 1'b0);
		rd(OFS_TALLY);
		chk(rdata, 32'h2);
		repeat (GAP + 10) @(posedge ref_clk);
		rd(OFS_TALLY);
		chk(rdata, 32'h0);
		rd(OFS_IRQ_STAT);
		chk(rdata & 32'h8, 32'h8);
		want[0] <= 1'b1;
		repeat (LNG + 30) @(posedge ref_clk);
		rd(OFS_LONG);
		chk(rdata & 32'h1, 32'h1);
		key(0, 1'b0);
		key(0, 1'b1);
		key(0, 1'b0);
		rd(OFS_LONG);
		chk(rdata & 32'h1, 32'h0);
	endtask
	task t_text;
		wr(OFS_CFG, 32'h8c00);
		wr(OFS_CFG, 32'h8d00);
		rd(OFS_CFG);
		chk(rdata, 32'h8c00);
		put_text(1'b0, 33, 0);
		chk(rdata & 32'h7f00, 32'h2100);
		wr(OFS_TXT_RPTR, 32'h20);
		rd(OFS_TXT_RDAT);
		chk(rdata, 32'h41);
		wr(OFS_IRQ_STAT, 32'h3f);
		put_text(1'b0, 34, 0);
		chk(rdata & 32'h7f00, 32'h2100);
		rd(OFS_IRQ_STAT);
		chk(rdata & 32'h10, 32'h10);
		put_text(1'b1, 32, 2);
		chk(rdata & 32'h7f0000, 32'h200000);
		wr(OFS_TXT_RPTR, 32'h40);
		rd(OFS_TXT_RDAT);
		chk(rdata, 32'(SEMI_CHAR));
		wr(OFS_TXT_RPTR, 32'h5f);
		rd(OFS_TXT_RDAT);
		chk(rdata, 32'h41);
		put_text(1'b1, 31, 0);
		chk(rdata & 32'h7f0000, 32'h200000);
		put_text(1'b1, 33, 3);
		chk(rdata & 32'h7f0000, 32'h200000);
		wr(OFS_CFG, 32'h0);
		rd(OFS_TXT_CTRL);
		chk(rdata & 32'h7f0000, 32'h0);
		rd(OFS_CFG);
		chk(rdata, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_regs();
		t_moment();
		t_toggle();
		t_radio();
		t_clicks();
		t_text();
		end_sim();
	end
endmodule
